// ### rtl/wacc_pkg.sv
// shared constants and types for the weight accumulator with zero band
package wacc_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_TOTAL_LO = 4'h8;
    localparam logic [3:0] ADDR_TOTAL_HI = 4'hc;
    // control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_BAND_LSB = 1;
    localparam int CTRL_DEMAND_BIT = 5;
    localparam int CTRL_CONT_BIT = 6;
    localparam int CTRL_BATCH_BIT = 7;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // status field positions
    localparam int STAT_RECALL_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_CONFIRM_BIT = 2;
    localparam int STAT_REJECT_BIT = 3;
    // total: ten decimal digits held in binary
    localparam int TOTAL_W = 34;
    localparam logic [33:0] TOTAL_MAX = 34'h2540be3ff;
    localparam logic [33:0] TOTAL_RESET = 34'h000000000;
    // zero band codes: 0 off, 1..10 direct, 11..14 twenty to fifty
    localparam int BAND_CODE_W = 4;
    localparam logic [3:0] BAND_OFF = 4'h0;
    localparam logic [3:0] BAND_DIRECT_MAX = 4'ha;
    localparam int BAND_W = 6;
    // lamp flash half period
    localparam int CLK_HZ = 40_000_000;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
    // display prompt codes
    typedef enum logic [2:0] {
        WACC_P_NONE, WACC_P_PRINT, WACC_P_ACC, WACC_P_SURE,
        WACC_P_CLEAR, WACC_P_TOTAL
    } wacc_prompt_e;
endpackage

// ### rtl/wacc_top.sv
// weight accumulator with return-to-zero band, total recall and clear
`timescale 1ns/100ps
module wacc_top #(
    parameter int WT_W = 20,
    parameter int FLASH_CYC = wacc_pkg::FLASH_HALF_CYC
) (
    input wire logic ref_clk, // 40 MHz system clock
    input wire logic nrst, // async reset, active low
    input wire logic [3:0] addr, // register byte address
    input wire logic [31:0] wr_data, // register write data
    input wire logic wr_stb, // register write strobe
    input wire logic rd_stb, // register read strobe
    output logic [31:0] rd_data, // read data, cycle after rd_stb
    input wire logic signed [WT_W-1:0] wt_grads, // displayed weight
    input wire logic wt_motion, // scale in motion
    input wire logic wt_overload, // scale overloaded
    input wire logic print_key, // print key press pulse
    input wire logic print_cmd, // batch print command pulse
    input wire logic recall_key, // total recall key press pulse
    input wire logic ce_key, // clear entry key press pulse
    output logic print_req, // one-cycle weight print request
    output logic total_send, // send total on serial output
    output logic [wacc_pkg::TOTAL_W-1:0] total, // running total
    output wacc_pkg::wacc_prompt_e prompt, // display prompt
    output logic recall_lamp // total recall lamp
);
    import wacc_pkg::*;

    // refuse shapes the compare and flash counter cannot serve
    // above 35 bits a legal weight plus a full total could wrap the sum
    initial begin
        if (WT_W < 8 || WT_W > 35) begin
            $error("wacc_top: WT_W out of range");
        end
        if (FLASH_CYC < 1) begin
            $error("wacc_top: FLASH_CYC must be positive");
        end
    end

    // band code to graduations
    function automatic logic [BAND_W-1:0] band_of(
        input logic [BAND_CODE_W-1:0] code
    );
        logic [BAND_W-1:0] r;
        r = '0;
        if (code <= BAND_DIRECT_MAX) begin
            r = BAND_W'(code);
        end else if (code <= 4'he) begin
            r = BAND_W'((code - BAND_DIRECT_MAX + 4'h1) * 10);
        end
        return r;
    endfunction

    logic [CTRL_W-1:0] ctrl;
    logic recall;
    logic lock;
    logic confirm;
    logic reject;
    logic [31:0] flash_cnt;
    logic [TOTAL_W-1:0] next_total;
    wacc_prompt_e next_prompt;

    // control fields
    wire opt_en = ctrl[CTRL_ENABLE_BIT];
    wire [BAND_CODE_W-1:0] band_code =
        ctrl[CTRL_BAND_LSB +: BAND_CODE_W];
    wire demand = ctrl[CTRL_DEMAND_BIT];
    wire contin = ctrl[CTRL_CONT_BIT];
    wire automatic_batch_mode = ctrl[CTRL_BATCH_BIT];
    wire [BAND_W-1:0] band = band_of(band_code);
    wire band_on = band != '0;

    // magnitude of displayed weight for the zero band check
    wire wt_neg = wt_grads[WT_W-1];
    wire [WT_W-1:0] wt_mag = wt_neg ? WT_W'(-wt_grads) : WT_W'(wt_grads);
    wire in_band = wt_mag <= WT_W'(band);

    // add request and validity
    wire acc_req = opt_en && !recall &&
        (print_key || (print_cmd && automatic_batch_mode));
    wire wt_valid = !wt_motion && !wt_overload && !wt_neg;
    // a stale lock is ignored once the band is switched off
    wire try_add = acc_req && wt_valid && !(lock && band_on);
    wire [TOTAL_W:0] sum = {1'b0, total} +
        (TOTAL_W + 1)'(unsigned'(wt_grads));
    wire fits = sum <= {1'b0, TOTAL_MAX};
    wire do_add = try_add && fits;
    wire do_reject = try_add && !fits;

    // recall and clear keys
    wire recall_press = opt_en && recall_key;
    wire ce_in_recall = recall && ce_key;
    wire do_clear = ce_in_recall && confirm;

    // register write decode; the read mux compares addr on its own
    wire wr_ctrl = wr_stb && addr == ADDR_CTRL;
    wire wr_stat = wr_stb && addr == ADDR_STATUS;

    // total update: clear wins, otherwise add the weight
    always_comb begin
        next_total = total;
        if (do_clear) begin
            next_total = TOTAL_RESET;
        end else if (do_add) begin
            next_total = sum[TOTAL_W-1:0];
        end
    end

    // prompt selection after each operator event
    always_comb begin
        next_prompt = prompt;
        if (recall_press && recall) begin
            next_prompt = WACC_P_NONE;
        end else if (recall_press) begin
            next_prompt = WACC_P_TOTAL;
        end else if (do_clear) begin
            next_prompt = WACC_P_CLEAR;
        end else if (ce_in_recall) begin
            next_prompt = WACC_P_SURE;
        end else if (do_add) begin
            next_prompt = demand ? WACC_P_PRINT : WACC_P_ACC;
        end else if (!opt_en) begin
            next_prompt = WACC_P_NONE;
        end
    end

    // control register and reject flag, a new reject beats the clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= CTRL_RESET;
            reject <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wr_data[CTRL_W-1:0];
            end
            reject <= do_reject ||
                (reject && !(wr_stat && wr_data[STAT_REJECT_BIT]));
        end
    end

    // accumulator state
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            total <= TOTAL_RESET;
            prompt <= WACC_P_NONE;
            recall <= 1'b0;
            confirm <= 1'b0;
        end else begin
            total <= next_total;
            prompt <= next_prompt;
            recall <= opt_en && (recall ^ recall_press);
            // pending clear waits for the second press; leaving recall drops it
            confirm <= recall && !recall_press && (confirm ^ ce_key);
        end
    end

    // zero band lock: set by an add, freed once weight is near zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lock <= 1'b0;
        end else if (do_add && band_on) begin
            lock <= 1'b1;
        end else if (!band_on || in_band || !opt_en) begin
            lock <= 1'b0;
        end
    end

    // lamp flash timer; held idle outside recall so each recall starts lit
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flash_cnt <= '0;
            recall_lamp <= 1'b0;
        end else if (!recall) begin
            flash_cnt <= '0;
            recall_lamp <= 1'b0;
        end else if (flash_cnt >= 32'(FLASH_CYC) ||
                     recall_lamp == 1'b0 && flash_cnt == '0) begin
            flash_cnt <= 32'h1;
            recall_lamp <= !recall_lamp;
        end else begin
            flash_cnt <= flash_cnt + 32'h1;
        end
    end

    // serial requests: weight print follows an add, total in recall
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            print_req <= 1'b0;
            total_send <= 1'b0;
        end else begin
            print_req <= do_add && demand;
            total_send <= recall && !recall_press &&
                (contin || print_key);
        end
    end

    // read mux; unmapped addresses read zero
    wire [31:0] stat_word = {28'h0, reject, confirm, lock, recall};
    wire [31:0] rd_mux =
        addr == ADDR_CTRL ? {24'h0, ctrl} :
        addr == ADDR_STATUS ? stat_word :
        addr == ADDR_TOTAL_LO ? total[31:0] :
        addr == ADDR_TOTAL_HI ? {30'h0, total[TOTAL_W-1:32]} : 32'h0;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 32'h0;
        end else begin
            rd_data <= rd_stb ? rd_mux : 32'h0;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_added;
        do_add && band_on;
    endsequence
    sequence s_blocked;
        (!in_band && !recall_press && band_on && opt_en)
            [*2];
    endsequence

    a_total_cap: assert property (
        total <= TOTAL_MAX)
        else $error("total passed ten digits");
    a_disabled_no_add: assert property (
        !opt_en && !do_clear |=> total == $past(total))
        else $error("total changed while disabled");
    a_band_table: assert property (
        band_code == 4'hb |-> band == 6'd20)
        else $error("band code eleven not twenty");
    a_band_lock: assert property (
        s_added ##1 s_blocked |-> lock && !print_req)
        else $error("add not blocked outside band");
    a_band_off_free: assert property (
        !band_on && acc_req && wt_valid && fits
        |=> total == $past(total) + TOTAL_W'($past(wt_grads)))
        else $error("band off add missed");
    a_request_src: assert property (
        do_add |-> print_key || (print_cmd && automatic_batch_mode))
        else $error("add without request");
    a_valid_only: assert property (
        (wt_motion || wt_overload) |=> total == $past(total) ||
        $past(do_clear))
        else $error("invalid weight added");
    a_add_prompt: assert property (
        do_add && !recall_press |=> prompt ==
        ($past(demand) ? WACC_P_PRINT : WACC_P_ACC))
        else $error("wrong prompt after add");
    a_lamp_off: assert property (
        !recall |=> !recall_lamp || recall)
        else $error("lamp lit outside recall");
    a_total_print: assert property (
        recall && print_key && !recall_press |=> total_send)
        else $error("total not sent on print");
    a_clear_pair: assert property (
        recall && ce_key && confirm && !recall_press
        |=> total == '0 && prompt == WACC_P_CLEAR)
        else $error("second clear did not zero total");

    // refused adds, recall entry and the pending clear
    a_reject_sticky: assert property (
        do_reject |=> reject && total == $past(total))
        else $error("overflow add not refused");
    a_no_wrap: assert property (
        do_add |=> total >= $past(total))
        else $error("total wrapped on add");
    a_send_recall: assert property (
        total_send |-> $past(recall))
        else $error("total sent outside recall");
    a_recall_enter: assert property (
        opt_en && recall_key && !recall |=> recall && prompt == WACC_P_TOTAL)
        else $error("recall key did not show total");
    a_lamp_entry: assert property (
        $rose(recall) |=> recall_lamp)
        else $error("lamp not lit on recall entry");
    a_batch_gate: assert property (
        print_cmd && !print_key && !automatic_batch_mode
        |=> total == $past(total) || $past(do_clear))
        else $error("print command added outside batch");
    a_confirm_first: assert property (
        recall && ce_key && !confirm && !recall_press
        |=> prompt == WACC_P_SURE && confirm)
        else $error("first clear did not ask sure");
    a_confirm_hold: assert property (
        confirm && recall && !ce_key && !recall_press |=> confirm)
        else $error("pending clear dropped in recall");
    a_clear_recall_only: assert property (
        !recall && ce_key && !do_add |=> total == $past(total))
        else $error("clear key acted outside recall");
endmodule // wacc_top

// ### tb/wacc_pad.sv
// keypad and scale front end model facing the accumulator
`timescale 1ns/100ps
module wacc_pad (
    input wire logic ref_clk, // system clock
    output logic signed [34:0] wt, // displayed weight
    output logic [1:0] bad, // motion, overload
    output logic [3:0] keys // print, cmd, recall, ce
);
    // switches read low when released, never left floating
    initial begin
        wt = '0;
        bad = 2'b00;
        keys = 4'h0;
    end
    // new weight, then one settle cycle so the band test sees it
    task automatic set_wt(input longint w, input logic [1:0] f);
        @(posedge ref_clk);
        wt <= 35'(w);
        bad <= f;
        @(posedge ref_clk);
    endtask
    // one key held n cycles; n of 1 is a single press
    task automatic hold(input int k, input int n);
        @(posedge ref_clk);
        keys[k] <= 1'b1;
        repeat (n) @(posedge ref_clk);
        keys[k] <= 1'b0;
    endtask
endmodule // wacc_pad

// ### tb/wacc_top_tb.sv
// self-checking bench for the weight accumulator
`timescale 1ns/100ps
module wacc_top_tb;
    import wacc_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wr_data = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rd_data;
    logic signed [34:0] wt;
    logic [1:0] bad;
    logic [3:0] keys;
    logic print_req, total_send, recall_lamp, lamp_q;
    logic [TOTAL_W-1:0] total;
    wacc_prompt_e prompt;
    logic [2:0] m_prompt = WACC_P_NONE;
    logic [7:0] ctl = 8'h00;
    longint m_tot = 0;
    bit m_lock = 0;
    int mismatches = 0;
    int checks = 0;
    int seed = 31;
    int cyc = 0;
    int n;
    wacc_pad u_pad (.ref_clk(ref_clk), .wt(wt), .bad(bad), .keys(keys));
    wacc_top #(.WT_W(35), .FLASH_CYC(4)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .wt_grads(wt), .wt_motion(bad[0]), .wt_overload(bad[1]),
        .print_key(keys[0]), .print_cmd(keys[1]), .recall_key(keys[2]),
        .ce_key(keys[3]), .print_req(print_req), .total_send(total_send),
        .total(total), .prompt(prompt), .recall_lamp(recall_lamp));
    // 25 ns clock
    always #12.5 ref_clk = ~ref_clk;
    // hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_out(input string s, input logic [35:0] e,
                           input logic [35:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        checks++;
        if (rd_data !== e) begin
            mismatches++;
            $display("Error reg %0h expected %0h seen %0h", a, e, rd_data);
        end
    endtask
    function automatic int band(input logic [3:0] c);
        return (c == 4'hf) ? 0 : (c <= 4'ha) ? int'(c) : (c - 10) * 10 + 10;
    endfunction
    // disabling the option also drops the lock
    task automatic cfg(input logic [7:0] c);
        ctl = c;
        if (!c[0] || band(c[4:1]) == 0) m_lock = 0;
        wr(ADDR_CTRL, {24'h0, c});
    endtask
    task automatic wgt(input longint w, input logic [1:0] f);
        u_pad.set_wt(w, f);
        if ((w < 0 ? -w : w) <= band(ctl[4:1])) m_lock = 0;
    endtask
    // print (k 0) or batch command (k 1), modelled then compared
    task automatic key(input int k);
        longint w;
        bit go;
        w = wt;
        go = ctl[0] && !m_lock && bad == 2'b00 && w >= 0 &&
             (k == 0 || ctl[CTRL_BATCH_BIT]) && m_tot + w <= TOTAL_MAX;
        u_pad.hold(k, 1);
        #1;
        if (go) begin
            m_tot += w;
            m_lock = band(ctl[4:1]) != 0 && w > band(ctl[4:1]);
            m_prompt = ctl[CTRL_DEMAND_BIT] ? WACC_P_PRINT : WACC_P_ACC;
        end
        chk_out("total", m_tot, total);
        chk_out("prompt", m_prompt, prompt);
        chk_out("print_req", go && ctl[5], print_req);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        rd(4'h2, 32'h0);
        wgt(100, 2'b00);
        key(0);
        $display("test reset and disabled done");
        cfg(8'h01);
        for (int i = 0; i < 20; i++) begin
            wgt($random(seed) & 32'hfffff, (i % 5 == 0) ? 2'b01 :
                (i % 7 == 0) ? 2'b10 : 2'b00);
            key(0);
        end
        cfg(8'h21);
        key(0);
        key(1);
        cfg(8'ha1);
        key(1);
        wgt(-5, 2'b00);
        key(0);
        $display("test band off adds done");
        for (int c = 1; c < 16; c++) begin
            wgt(0, 2'b00);
            cfg(8'h01 | 8'(c << 1));
            wgt(7, 2'b00);
            key(0);
            if (c == 1) rd(ADDR_STATUS, 32'h2);
            wgt(band(c) + 1, 2'b00);
            key(0);
            wgt(band(c), 2'b00);
            key(0);
        end
        $display("test zero band done");
        u_pad.hold(2, 1);
        #1;
        chk_out("prompt", WACC_P_TOTAL, prompt);
        lamp_q = recall_lamp;
        n = 0;
        for (int i = 0; i < 12; i++) begin
            @(posedge ref_clk);
            #1;
            if (recall_lamp !== lamp_q) n++;
            lamp_q = recall_lamp;
        end
        chk_out("lamp_flash", 3, n);
        u_pad.hold(0, 1);
        #1;
        chk_out("total_send", 1, total_send);
        chk_out("total", m_tot, total);
        cfg(8'h41);
        repeat (2) @(posedge ref_clk);
        repeat (3) begin
            @(posedge ref_clk);
            #1;
            chk_out("total_send", 1, total_send);
        end
        cfg(8'h01);
        @(posedge ref_clk);
        #1;
        chk_out("total_send", 0, total_send);
        u_pad.hold(3, 1);
        #1;
        chk_out("prompt", WACC_P_SURE, prompt);
        u_pad.hold(2, 1);
        u_pad.hold(2, 1);
        u_pad.hold(3, 1);
        #1;
        chk_out("total", m_tot, total);
        u_pad.hold(3, 1);
        #1;
        m_tot = 0;
        chk_out("total", m_tot, total);
        chk_out("prompt", WACC_P_CLEAR, prompt);
        $display("test recall and clear done");
        u_pad.hold(2, 1);
        wgt(TOTAL_MAX, 2'b00);
        key(0);
        wgt(1, 2'b00);
        key(0);
        rd(ADDR_STATUS, 32'h8);
        rd(ADDR_TOTAL_LO, 32'(m_tot));
        rd(ADDR_TOTAL_HI, 32'(m_tot >> 32));
        wr(ADDR_STATUS, 32'h8);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_CTRL, 32'h1);
        $display("test capacity done");
        end_of_test();
    end
endmodule // wacc_top_tb
